//--- rtl/dlpck_pkg.sv
package dlpck_pkg;
    // register byte address and field layout
    localparam logic [11:0] DLPCK_CTRL_ADDR    = 12'h004;
    localparam int          DLPCK_SLEEP_BIT    = 0;
    localparam int          DLPCK_STOP_BIT     = 1;
    localparam int          DLPCK_STANDBY_BIT  = 2;
    localparam int          DLPCK_IWDG_BIT     = 8;
    localparam logic [31:0] DLPCK_CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] DLPCK_CTRL_MASK    = 32'h0000_0107;
    localparam logic [1:0]  DLPCK_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  DLPCK_RESP_SLVERR  = 2'h2;
    // clock source select codes
    localparam logic [1:0]  DLPCK_SRC_NONE     = 2'h0;
    localparam logic [1:0]  DLPCK_SRC_SYSCLK   = 2'h1;
    localparam logic [1:0]  DLPCK_SRC_RC_OSC   = 2'h2;

    typedef enum logic [3:0] {
        DLPCK_RUN     = 4'h1,
        DLPCK_SLEEP   = 4'h2,
        DLPCK_STOP    = 4'h4,
        DLPCK_STANDBY = 4'h8
    } dlpck_mode_e;
endpackage

//--- rtl/dlpck_gate_decode.sv
`timescale 1ns/1ps
module dlpck_gate_decode
    import dlpck_pkg::*;
(
    // mode and settings
    input  wire dlpck_mode_e mode,
    input  wire logic [31:0] ctrl,
    input  wire logic        core_halted,
    // decoded controls
    output logic             core_clk_en,
    output logic             bus_clk_en,
    output logic [1:0]       clk_src,
    output logic             digital_power_on,
    output logic             watchdog_freeze
);
    always_comb begin
        core_clk_en      = 1'b1;
        bus_clk_en       = 1'b1;
        clk_src          = DLPCK_SRC_SYSCLK;
        digital_power_on = 1'b1;
        watchdog_freeze  = core_halted && ctrl[DLPCK_IWDG_BIT]; // see [R01] see [R15]
        case (mode)
            DLPCK_RUN: begin
            end
            DLPCK_SLEEP: begin
                // configured system clock kept, nothing reprogrammed
                bus_clk_en = ctrl[DLPCK_SLEEP_BIT]; // see [R11] see [R12] see [R13]
            end
            DLPCK_STOP: begin
                core_clk_en = ctrl[DLPCK_STOP_BIT]; // see [R07] see [R09]
                bus_clk_en  = ctrl[DLPCK_STOP_BIT];
                clk_src     = ctrl[DLPCK_STOP_BIT] ? DLPCK_SRC_RC_OSC : DLPCK_SRC_NONE;
            end
            DLPCK_STANDBY: begin
                core_clk_en      = ctrl[DLPCK_STANDBY_BIT]; // see [R03] see [R05]
                bus_clk_en       = ctrl[DLPCK_STANDBY_BIT];
                clk_src          = ctrl[DLPCK_STANDBY_BIT] ? DLPCK_SRC_RC_OSC : DLPCK_SRC_NONE;
                digital_power_on = ctrl[DLPCK_STANDBY_BIT];
            end
            default: begin
            end
        endcase
    end
endmodule

//--- rtl/dlpck_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] With the watchdog freeze bit at 0 the watchdog counts during a debug halt, at 1 it holds.
// [R02] Software leaves reserved bits 7 to 3 at their reset value.
// [R03] With the standby bit at 0, standby stops both clocks and powers off the digital circuit.
// [R04] Leaving such a powered-off standby looks like a reset, with a flag reporting standby exit.
// [R05] With the standby bit at 1, the circuit stays powered and both clocks run from the RC oscillator.
// [R06] With the standby bit at 1, leaving standby still goes through a system reset.
// [R07] With the stop bit at 0, all clocks including core and bus clocks are gated in stop mode.
// [R08] Leaving stop returns the clock setup to its post-reset state on the 8MHz RC oscillator.
// [R09] With the stop bit at 1, core and bus clocks run from the RC oscillator throughout stop.
// [R10] After any stop exit software re-enables the PLL, crystal oscillator and other sources.
// [R11] With the sleep bit at 0, the core clock keeps the system clock in sleep and the bus clock is gated.
// [R12] Sleep leaves the clock setup untouched so no reprogramming is needed on wake.
// [R13] With the sleep bit at 1, core and bus clocks both keep the system clock in sleep.
// [R14] The standby, stop, sleep and watchdog bits are writable to either value and hold it.
// [R15] The watchdog freeze applies only while the core is halted in debug.
// [R16] The control register clears only on power-on reset and survives a system reset.
// [R17] A read returns the implemented bits as written and zeros elsewhere.
module dlpck_top
    import dlpck_pkg::*;
(
    // clock and resets
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        sys_resetn,
    // power-mode requests, same clock domain
    input  wire logic        sleep_req,
    input  wire logic        stop_req,
    input  wire logic        standby_req,
    input  wire logic        wakeup,
    input  wire logic        core_halted,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // clock gating and power controls
    output logic             core_clk_en,
    output logic             bus_clk_en,
    output logic [1:0]       clk_src,
    output logic             digital_power_on,
    output logic             watchdog_freeze,
    output logic             clk_cfg_reset,
    output logic             sys_reset_req,
    output logic             standby_exit_flag
);
    typedef struct packed {
        logic [31:0] ctrl;
        dlpck_mode_e mode;
        logic        aw_got;
        logic [11:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        core_clk_en;
        logic        bus_clk_en;
        logic [1:0]  clk_src;
        logic        power_on;
        logic        wdg_freeze;
        logic        cfg_reset;
        logic        reset_req;
        logic        standby_exit;
    } dlpck_state_s;

    dlpck_state_s state;
    dlpck_state_s next_state;

    logic        dec_core_en;
    logic        dec_bus_en;
    logic [1:0]  dec_src;
    logic        dec_power;
    logic        dec_wdg;
    logic [31:0] merged;

    dlpck_gate_decode u_decode (
        .mode             (next_state.mode),
        .ctrl             (next_state.ctrl),
        .core_halted      (core_halted),
        .core_clk_en      (dec_core_en),
        .bus_clk_en       (dec_bus_en),
        .clk_src          (dec_src),
        .digital_power_on (dec_power),
        .watchdog_freeze  (dec_wdg)
    );

    always_comb begin
        next_state           = state;
        next_state.cfg_reset = 1'b0;
        next_state.reset_req = 1'b0;
        merged               = state.ctrl;

        // address and data may arrive in either order
        if (state.awready && s_axi_awvalid) begin
            next_state.aw_got  = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
            next_state.awready = 1'b0;
        end
        if (state.wready && s_axi_wvalid) begin
            next_state.w_got  = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
            next_state.wready = 1'b0;
        end
        if (state.aw_got && state.w_got && !state.bvalid) begin
            next_state.bvalid = 1'b1;
            next_state.aw_got = 1'b0;
            next_state.w_got  = 1'b0;
            if (state.aw_addr[11:2] == DLPCK_CTRL_ADDR[11:2]) begin
                for (int i = 0; i < 4; i++) begin
                    if (state.w_strb[i]) begin
                        merged[i*8 +: 8] = state.w_data[i*8 +: 8];
                    end
                end
                // reserved and unmodelled freeze bits stay zero
                next_state.ctrl  = merged & DLPCK_CTRL_MASK; // see [R14] see [R02]
                next_state.bresp = DLPCK_RESP_OKAY;
            end else begin
                next_state.bresp = DLPCK_RESP_SLVERR;
            end
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid  = 1'b0;
            next_state.awready = 1'b1;
            next_state.wready  = 1'b1;
        end

        if (state.arready && s_axi_arvalid) begin
            next_state.arready = 1'b0;
            next_state.rvalid  = 1'b1;
            if (s_axi_araddr[11:2] == DLPCK_CTRL_ADDR[11:2]) begin
                next_state.rdata = state.ctrl & DLPCK_CTRL_MASK; // see [R17]
                next_state.rresp = DLPCK_RESP_OKAY;
            end else begin
                next_state.rdata = 32'h0000_0000;
                next_state.rresp = DLPCK_RESP_SLVERR;
            end
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end

        // a system reset clears the flag but never the control word
        if (!sys_resetn) begin
            next_state.mode         = DLPCK_RUN;
            next_state.standby_exit = 1'b0;
        end else begin
            case (state.mode)
                DLPCK_RUN: begin
                    if (standby_req) begin
                        next_state.mode = DLPCK_STANDBY;
                    end else if (stop_req) begin
                        next_state.mode = DLPCK_STOP;
                    end else if (sleep_req) begin
                        next_state.mode = DLPCK_SLEEP;
                    end
                end
                DLPCK_SLEEP: begin
                    if (wakeup) begin
                        next_state.mode = DLPCK_RUN; // see [R12]
                    end
                end
                DLPCK_STOP: begin
                    if (wakeup) begin
                        next_state.mode      = DLPCK_RUN;
                        next_state.cfg_reset = 1'b1; // see [R08]
                    end
                end
                DLPCK_STANDBY: begin
                    if (wakeup) begin
                        next_state.mode         = DLPCK_RUN;
                        next_state.reset_req    = 1'b1; // see [R04] see [R06]
                        next_state.standby_exit = 1'b1; // see [R04]
                    end
                end
                default: begin
                    next_state.mode = DLPCK_RUN;
                end
            endcase
        end

        next_state.core_clk_en = dec_core_en;
        next_state.bus_clk_en  = dec_bus_en;
        next_state.clk_src     = dec_src;
        next_state.power_on    = dec_power;
        next_state.wdg_freeze  = dec_wdg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state              <= '0;
            state.ctrl         <= DLPCK_CTRL_RESET; // see [R16]
            state.mode         <= DLPCK_RUN;
            state.awready      <= 1'b1;
            state.wready       <= 1'b1;
            state.arready      <= 1'b1;
            state.core_clk_en  <= 1'b1;
            state.bus_clk_en   <= 1'b1;
            state.clk_src      <= DLPCK_SRC_SYSCLK;
            state.power_on     <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready     = state.awready;
    assign s_axi_wready      = state.wready;
    assign s_axi_bvalid      = state.bvalid;
    assign s_axi_bresp       = state.bresp;
    assign s_axi_arready     = state.arready;
    assign s_axi_rvalid      = state.rvalid;
    assign s_axi_rdata       = state.rdata;
    assign s_axi_rresp       = state.rresp;
    assign core_clk_en       = state.core_clk_en;
    assign bus_clk_en        = state.bus_clk_en;
    assign clk_src           = state.clk_src;
    assign digital_power_on  = state.power_on;
    assign watchdog_freeze   = state.wdg_freeze;
    assign clk_cfg_reset     = state.cfg_reset;
    assign sys_reset_req     = state.reset_req;
    assign standby_exit_flag = state.standby_exit;

    sequence s_enter_standby;
        state.mode == DLPCK_RUN && sys_resetn && standby_req;
    endsequence

    property p_wdg_freeze;
        @(posedge aclk) disable iff (!aresetn)
        ##1 watchdog_freeze == ($past(core_halted) && state.ctrl[DLPCK_IWDG_BIT]);
    endproperty
    a_wdg_freeze: assert property (p_wdg_freeze) else $error("watchdog freeze mismatch"); // see [R01]

    property p_wdg_run;
        @(posedge aclk) disable iff (!aresetn)
        !core_halted |=> !watchdog_freeze;
    endproperty
    a_wdg_run: assert property (p_wdg_run) else $error("watchdog frozen outside halt"); // see [R15]

    property p_standby_off;
        @(posedge aclk) disable iff (!aresetn)
        s_enter_standby and !state.ctrl[DLPCK_STANDBY_BIT] && !(state.aw_got && state.w_got) |=>
            !digital_power_on && !core_clk_en && !bus_clk_en;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("standby did not power down"); // see [R03]

    property p_standby_on;
        @(posedge aclk) disable iff (!aresetn)
        s_enter_standby and state.ctrl[DLPCK_STANDBY_BIT] && !(state.aw_got && state.w_got) |=>
            digital_power_on && core_clk_en && bus_clk_en && clk_src == DLPCK_SRC_RC_OSC;
    endproperty
    a_standby_on: assert property (p_standby_on) else $error("standby debug clocks wrong"); // see [R05]

    property p_standby_exit;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_STANDBY && sys_resetn && wakeup |=> sys_reset_req && standby_exit_flag;
    endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("standby exit without reset"); // see [R06]

    property p_stop_clocks;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_STOP |-> core_clk_en == state.ctrl[DLPCK_STOP_BIT]
            && bus_clk_en == state.ctrl[DLPCK_STOP_BIT];
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) else $error("stop clock gating wrong"); // see [R07]

    property p_stop_exit;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_STOP && sys_resetn && wakeup |=> clk_cfg_reset ##1 !clk_cfg_reset;
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("stop exit config reset missing"); // see [R08]

    property p_sleep;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_SLEEP |-> core_clk_en && clk_src == DLPCK_SRC_SYSCLK
            && bus_clk_en == state.ctrl[DLPCK_SLEEP_BIT];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep gating wrong"); // see [R11]

    property p_read_back;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == DLPCK_CTRL_ADDR[11:2] |=>
            s_axi_rvalid && s_axi_rdata == ($past(state.ctrl) & DLPCK_CTRL_MASK);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong"); // see [R17]

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        !(state.aw_got && state.w_got && !state.bvalid) |=> $stable(state.ctrl);
    endproperty
    a_hold: assert property (p_hold) else $error("control changed without write"); // see [R14] see [R16]

    property p_stop_src;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_STOP && state.ctrl[DLPCK_STOP_BIT] |-> clk_src == DLPCK_SRC_RC_OSC;
    endproperty
    a_stop_src: assert property (p_stop_src) else $error("stop debug clock source wrong"); // see [R09]

    property p_sleep_exit;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_SLEEP && sys_resetn && wakeup |=>
            !clk_cfg_reset && !sys_reset_req && clk_src == DLPCK_SRC_SYSCLK;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit touched clock setup"); // see [R12]

    property p_run_clocks;
        @(posedge aclk) disable iff (!aresetn)
        state.mode == DLPCK_RUN |-> core_clk_en && bus_clk_en && digital_power_on && clk_src == DLPCK_SRC_SYSCLK;
    endproperty
    a_run_clocks: assert property (p_run_clocks) else $error("run mode clocks wrong"); // see [R12]

    property p_flag_sticky;
        @(posedge aclk) disable iff (!aresetn)
        standby_exit_flag && sys_resetn |=> standby_exit_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("standby exit flag lost"); // see [R04]

    property p_ctrl_sys_reset;
        @(posedge aclk) disable iff (!aresetn)
        !sys_resetn && !(state.aw_got && state.w_got) |=> $stable(state.ctrl) && !standby_exit_flag;
    endproperty
    a_ctrl_sys_reset: assert property (p_ctrl_sys_reset) else $error("system reset disturbed control"); // see [R16]
endmodule

//--- test/dlpck_axi_master.sv
`timescale 1ns/1ps
// stands in for software on the register bus, one transfer at a time
module dlpck_axi_master (
    // clock
    input  wire logic        aclk,
    // requests
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    output logic             s_axi_bready,
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    output logic             s_axi_rready,
    // answers
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid
);
    initial begin
        s_axi_awaddr  = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0000_0000;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
    end
    // released payload is scrambled so a slave cannot lean on stale values
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                break;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule

//--- test/tb_debug_lowpower_clock_keep.sv
`timescale 1ns/1ps
module tb_debug_lowpower_clock_keep
    import dlpck_pkg::*;
;
    logic        aclk, aresetn, sys_resetn, sleep_req, stop_req, standby_req, wakeup, core_halted;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, clk_src;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic        core_clk_en, bus_clk_en, digital_power_on, watchdog_freeze;
    logic        clk_cfg_reset, sys_reset_req, standby_exit_flag, cfg, sysr;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;

    dlpck_top i_dut (.aclk(aclk), .aresetn(aresetn), .sys_resetn(sys_resetn), .sleep_req(sleep_req),
        .stop_req(stop_req), .standby_req(standby_req), .wakeup(wakeup), .core_halted(core_halted),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en), .clk_src(clk_src),
        .digital_power_on(digital_power_on), .watchdog_freeze(watchdog_freeze),
        .clk_cfg_reset(clk_cfg_reset), .sys_reset_req(sys_reset_req), .standby_exit_flag(standby_exit_flag));

    dlpck_axi_master i_host (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rready(rready), .s_axi_awready(awready),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid));

    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] pk(logic c, logic b, logic [1:0] s, logic p);
        return 32'({c, b, s, p});
    endfunction

    function automatic logic [31:0] outs();
        return pk(core_clk_en, bus_clk_en, clk_src, digital_power_on);
    endfunction

    task automatic set_ctrl(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        i_host.wr(a, d, 4'hf, r);
        chk(32'(r), 32'(er), "write response");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        i_host.rd(a, d, r);
        chk(d, ed, "read data");
        chk(32'(r), 32'(er), "read response");
    endtask

    // one-cycle request; requests are only sampled in run mode
    task automatic enter(input int m);
        @(posedge aclk);
        sleep_req   <= (m == 0);
        stop_req    <= (m == 1);
        standby_req <= (m == 2);
        @(posedge aclk);
        sleep_req   <= 1'b0;
        stop_req    <= 1'b0;
        standby_req <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic leave();
        cfg = 1'b0;
        sysr = 1'b0;
        @(posedge aclk);
        wakeup <= 1'b1;
        repeat (6) begin
            @(posedge aclk);
            wakeup <= 1'b0;
            cfg = cfg | clk_cfg_reset;
            sysr = sysr | sys_reset_req;
        end
    endtask

    task automatic sys_rst();
        @(posedge aclk);
        sys_resetn <= 1'b0;
        repeat (2) @(posedge aclk);
        sys_resetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic t_regs();
        logic [1:0] r;
        rd_chk(DLPCK_CTRL_ADDR, 32'h0000_0000, DLPCK_RESP_OKAY);
        chk(outs(), pk(1'b1, 1'b1, DLPCK_SRC_SYSCLK, 1'b1), "run");
        set_ctrl(DLPCK_CTRL_ADDR, 32'hffff_ff07, DLPCK_RESP_OKAY);
        rd_chk(DLPCK_CTRL_ADDR, 32'h0000_0107, DLPCK_RESP_OKAY);
        i_host.wr(DLPCK_CTRL_ADDR, 32'h0000_0000, 4'h1, r);
        chk(32'(r), 32'(DLPCK_RESP_OKAY), "strobe write");
        rd_chk(DLPCK_CTRL_ADDR, 32'h0000_0100, DLPCK_RESP_OKAY);
        set_ctrl(12'h008, 32'h0000_0001, DLPCK_RESP_SLVERR);
        rd_chk(12'h008, 32'h0000_0000, DLPCK_RESP_SLVERR);
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0000, DLPCK_RESP_OKAY);
        rd_chk(DLPCK_CTRL_ADDR, 32'h0000_0000, DLPCK_RESP_OKAY);
    endtask

    task automatic t_sleep();
        enter(0);
        chk(outs(), pk(1'b1, 1'b0, DLPCK_SRC_SYSCLK, 1'b1), "sleep");
        leave();
        chk(32'(cfg), 32'h0, "sleep wake cfg");
        chk(outs(), pk(1'b1, 1'b1, DLPCK_SRC_SYSCLK, 1'b1), "wake");
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0001, DLPCK_RESP_OKAY);
        enter(0);
        chk(outs(), pk(1'b1, 1'b1, DLPCK_SRC_SYSCLK, 1'b1), "dbg sleep");
        leave();
    endtask

    task automatic t_stop();
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0000, DLPCK_RESP_OKAY);
        enter(1);
        chk(32'({core_clk_en, bus_clk_en}), 32'h0, "stop clocks");
        leave();
        chk(32'(cfg), 32'h1, "stop exit cfg");
        // software restarts its clock sources here
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0002, DLPCK_RESP_OKAY);
        enter(1);
        chk(outs(), pk(1'b1, 1'b1, DLPCK_SRC_RC_OSC, 1'b1), "dbg stop");
        leave();
        chk(32'(cfg), 32'h1, "dbg stop exit cfg");
    endtask

    task automatic t_standby();
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0000, DLPCK_RESP_OKAY);
        enter(2);
        chk(32'({core_clk_en, bus_clk_en, digital_power_on}), 32'h0, "standby off");
        leave();
        chk(32'({sysr, standby_exit_flag}), 32'h3, "standby exit");
        sys_rst();
        chk(32'(standby_exit_flag), 32'h0, "flag after sys reset");
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0004, DLPCK_RESP_OKAY);
        enter(2);
        chk(outs(), pk(1'b1, 1'b1, DLPCK_SRC_RC_OSC, 1'b1), "dbg stby");
        leave();
        chk(32'(sysr), 32'h1, "dbg standby exit");
        sys_rst();
        rd_chk(DLPCK_CTRL_ADDR, 32'h0000_0004, DLPCK_RESP_OKAY);
    endtask

    task automatic t_watchdog();
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0100, DLPCK_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(32'(watchdog_freeze), 32'h0, "freeze not halted");
        core_halted <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(watchdog_freeze), 32'h1, "freeze halted");
        set_ctrl(DLPCK_CTRL_ADDR, 32'h0000_0000, DLPCK_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(32'(watchdog_freeze), 32'h0, "freeze bit clear");
        core_halted <= 1'b0;
    endtask

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        aresetn = 1'b0;
        sys_resetn = 1'b1;
        sleep_req = 1'b0;
        stop_req = 1'b0;
        standby_req = 1'b0;
        wakeup = 1'b0;
        core_halted = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_sleep();
        t_stop();
        t_standby();
        t_watchdog();
        stop_test();
    end
endmodule
